//--- tb.sv
// Testbench for the watchdog and discharge timer
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wake = 1'b0;
  logic soft_timer_enable_pin = 1'b0;
  logic therm = 1'b0;
  logic hsel, hwrite, hready, hresp, oe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] dis;
  logic [31:0] haddr, hwdata, hrdata, q;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  wdt_top #(.WDOG_CYC(200), .HALFMIN_CYC(20)) wdt_top_inst (.I_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_WAKE(wake),
    .I_SOFT_TIMER_ENABLE_PIN(soft_timer_enable_pin), .I_THERMAL_TRIP(therm), .O_WATCHDOG_EXPIRED_PIN_OE(oe), .O_DISCHARGE(dis));
  wdt_host wdt_host_inst (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
  // ==========
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    wdt_host_inst.xfer(1'b1, a, d, r);
  endtask
  // Read data stand in the data phase and are taken at its closing edge
  task automatic rd(input logic [31:0] a);
    wdt_host_inst.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic cfg(input logic [31:0] lo, input logic [15:0] hi);
    wr(`WDT_OFS_WAKE, 32'h0000_0001);
    wr(`WDT_OFS_WDATA_LO, lo);
    wr(`WDT_OFS_WDATA_HI, {16'h0000, hi});
    wr(`WDT_OFS_CMD, 32'h0000_0001);
    repeat (3) @(posedge clk);
  endtask
  task automatic wake_pulse;
    @(posedge clk);
    wake <= 1'b1;
    repeat (6) @(posedge clk);
    wake <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk(32'(oe), 32'h0000_0001);
    chk(32'(dis), 32'h0000_0000);
    rd(`WDT_OFS_STATB);
    chk(q, 32'h0000_0010);
    wr(32'h0000_0040, 32'hFFFF_FFFF);
    rd(32'h0000_0040);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_watchdog;
    cfg(32'h0000_00FF, 16'h5ABC);
    chk(32'(dis), 32'h0000_0ABC);
    wake_pulse();
    repeat (180) @(posedge clk);
    chk(32'(oe), 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk(32'(oe), 32'h0000_0000);
    chk(32'(dis), 32'h0000_0000);
    rd(`WDT_OFS_CFG_LO);
    chk(q, 32'h0000_0000);
    rd(`WDT_OFS_STATUS);
    chk(q, 32'h0000_0002);
    wake_pulse();
    repeat (4) @(posedge clk);
    chk(32'(oe), 32'h0000_0001);
  endtask
  task automatic t_codes;
    soft_timer_enable_pin <= 1'b1;
    for (int c = 1; c < 16; c++) begin
      cfg(32'h0000_0000, {c[3:0], 12'hABC});
      rd(`WDT_OFS_CFG_HI);
      chk(q, {16'h0000, c[3:0], 12'hABC});
    end
    cfg(32'h0000_0000, 16'h0ABC);
    repeat (220) @(posedge clk);
    chk(32'(dis), 32'h0000_0000);
  endtask
  task automatic t_timer;
    cfg(32'h1234_5678, 16'h2ABC);
    wr(`WDT_OFS_CMD, 32'h0000_0002);
    rd(`WDT_OFS_RDATA_HI);
    chk(q, 32'h0000_2ABC);
    wr(`WDT_OFS_CMD, 32'h0000_0004);
    repeat (15) @(posedge clk);
    rd(`WDT_OFS_CFG_HI);
    chk(32'(q[15:12]), 32'h0000_0001);
    repeat (20) @(posedge clk);
    chk(32'(dis), 32'h0000_0000);
    rd(`WDT_OFS_CFG_LO);
    chk(q, 32'h1234_5678);
    rd(`WDT_OFS_CFG_HI);
    chk(q, 32'h0000_0000);
    cfg(32'h1234_5678, 16'hFABC);
    repeat (220) @(posedge clk);
    chk(32'(oe), 32'h0000_0000);
    chk(32'(dis), 32'h0000_0ABC);
    rd(`WDT_OFS_CFG_LO);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_thermal;
    soft_timer_enable_pin <= 1'b0;
    cfg(32'h0000_0000, 16'h0ABC);
    wr(`WDT_OFS_CMD, 32'h0000_0004);
    chk(32'(dis), 32'h0000_0ABC);
    wr(`WDT_OFS_CMD, 32'h0000_0003);
    rd(`WDT_OFS_RDATA_LO);
    chk(q, 32'h0000_0011);
    rd(`WDT_OFS_STATB);
    chk(q, 32'h0000_0010);
    therm <= 1'b1;
    repeat (6) @(posedge clk);
    therm <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(dis), 32'h0000_0000);
    rd(`WDT_OFS_STATB);
    chk(q, 32'h0000_0011);
    rd(`WDT_OFS_STATB);
    chk(q, 32'h0000_0010);
  endtask
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_watchdog();
    t_codes();
    t_timer();
    t_thermal();
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- wdt_checker.sv
// Port checker for the watchdog and discharge timer
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"
module wdt_checker #(parameter int unsigned WDOG_CYC = 50) (
  input wire logic I_CLK, // Clock
  input wire logic I_RST, // Reset
  input wire logic I_HSEL, // Select
  input wire logic [31:0] I_HADDR, // Address
  input wire logic [1:0] I_HTRANS, // Transfer type
  input wire logic I_HWRITE, // Write
  input wire logic I_HREADY, // Ready in
  input wire logic I_WAKE, // Wake pin
  input wire logic I_THERMAL_TRIP, // Thermal pin
  input wire logic O_HREADYOUT, // Ready out
  input wire logic O_HRESP, // Response
  input wire logic O_WATCHDOG_EXPIRED_PIN_OE, // Expired pin drive
  input wire logic [11:0] O_DISCHARGE // Switches
);
  // ==========
  // Helper state
  logic [31:0] quiet;
  logic [3:0] cmd_hist;
  logic wr_ok, wake_prev;
  assign wr_ok = I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
  always_ff @(posedge I_CLK) begin
    if (I_RST) wake_prev <= 1'b0;
    else wake_prev <= I_WAKE;
  end
  // Restarts on the pin's rising edge, so it runs ahead of the synchronised count
  always_ff @(posedge I_CLK) begin
    if (I_RST || (I_WAKE && !wake_prev) || (wr_ok && I_HADDR == `WDT_OFS_WAKE)) quiet <= 32'h0000_0000;
    else if (quiet != 32'hFFFF_FFFF) quiet <= quiet + 32'h0000_0001;
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) cmd_hist <= 4'h0;
    else cmd_hist <= {cmd_hist[2:0], wr_ok && I_HADDR == `WDT_OFS_CMD};
  end
  // ==========
  // Properties
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_ready_high: assert property (O_HREADYOUT) else $error("ready dropped");
  a_resp_okay: assert property (!O_HRESP) else $error("error response");
  a_reset_state: assert property ($fell(I_RST) |-> O_WATCHDOG_EXPIRED_PIN_OE && O_DISCHARGE == 12'h000)
    else $error("bad state after reset");
  a_wdog_early: assert property ($fell(O_WATCHDOG_EXPIRED_PIN_OE) |-> quiet >= WDOG_CYC)
    else $error("watchdog expired early");
  a_wdog_fires: assert property (quiet == WDOG_CYC + 20 |-> !O_WATCHDOG_EXPIRED_PIN_OE)
    else $error("watchdog did not expire");
  a_wake_rearms: assert property ($rose(I_WAKE) |-> ##[1:10] O_WATCHDOG_EXPIRED_PIN_OE)
    else $error("wake did not restart watchdog");
  a_thermal_off: assert property ($rose(I_THERMAL_TRIP) |-> ##[1:10] O_DISCHARGE == 12'h000)
    else $error("thermal trip left switches on");
  a_load_cause: assert property ($changed(O_DISCHARGE) && O_DISCHARGE != 12'h000 |-> |cmd_hist)
    else $error("switches turned on without a write");
  c_expire: cover property ($fell(O_WATCHDOG_EXPIRED_PIN_OE));
  c_thermal: cover property ($rose(I_THERMAL_TRIP));
  c_timer_off: cover property ($fell(|O_DISCHARGE) && O_WATCHDOG_EXPIRED_PIN_OE);
endmodule
bind wdt_top wdt_checker #(.WDOG_CYC(WDOG_CYC)) wdt_checker_inst (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
  .I_WAKE(I_WAKE), .I_THERMAL_TRIP(I_THERMAL_TRIP), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
  .O_WATCHDOG_EXPIRED_PIN_OE(O_WATCHDOG_EXPIRED_PIN_OE), .O_DISCHARGE(O_DISCHARGE));
`default_nettype wire

//--- wdt_host.sv
// Host controller model: single-word bus master
`timescale 1ns/1ns
`default_nettype none
module wdt_host (
  input wire logic i_clk, // Clock
  input wire logic i_hready, // Bus ready
  input wire logic [31:0] i_hrdata, // Read data
  output logic o_hsel, // Select
  output logic [31:0] o_haddr, // Address
  output logic [1:0] o_htrans, // Transfer type
  output logic o_hwrite, // Write
  output logic [2:0] o_hsize, // Size, always a word
  output logic [31:0] o_hwdata // Write data
);
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0000_0000;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize = 3'b010;
    o_hwdata = 32'h0000_0000;
  end
  // ==========
  // Transfer; bytes four and five read while the timer fires may be stale
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_htrans <= 2'b10;
    o_hwrite <= w;
    do @(posedge i_clk); while (!i_hready);
    o_hsel <= 1'b0;
    o_htrans <= 2'b00;
    o_hwdata <= w ? d : ~o_hwdata;
    do @(posedge i_clk); while (!i_hready);
    q = i_hrdata;
    // Released data lines must not keep looking valid
    o_hwdata <= ~o_hwdata;
  endtask
endmodule
`default_nettype wire

//--- wdt_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_OFS_CFG_LO 32'h0000_0000
`define WDT_OFS_CFG_HI 32'h0000_0004
`define WDT_OFS_WDATA_LO 32'h0000_0008
`define WDT_OFS_WDATA_HI 32'h0000_000C
`define WDT_OFS_CMD 32'h0000_0010
`define WDT_OFS_STATB 32'h0000_0014
`define WDT_OFS_STATUS 32'h0000_0018
`define WDT_OFS_WAKE 32'h0000_001C
`define WDT_OFS_RDATA_LO 32'h0000_0020
`define WDT_OFS_RDATA_HI 32'h0000_0024
`define WDT_CFG_RESET 48'h0000_0000_0000
`define WDT_DISCHARGE_TIMEOUT_CODE_LSB 4
`define WDT_THERMAL_SHUTDOWN_FLAG_BIT 0
`define WDT_REV_LSB 4
`define WDT_WDOG_MS 2000
`define WDT_CLK_HZ 10000000
`define WDT_WDOG_CYC ((`WDT_WDOG_MS) * (`WDT_CLK_HZ / 1000))
`define WDT_HALFMIN_CYC (30 * `WDT_CLK_HZ)
`endif

//--- wdt_pkg.sv
// Package of shared types for the watchdog and discharge timer block
package wdt_pkg;
  // One bus request as seen in the address phase
  typedef struct packed {
    logic [31:0] addr;
    logic write;
  } wdt_req_s;
  // Host command codes written to the command register
  typedef enum logic [3:0] {
    WDT_CMD_NONE = 4'h0,
    WDT_CMD_WRITE_CONFIG_CMD = 4'h1,
    WDT_CMD_READ_CONFIG_CMD = 4'h2,
    WDT_CMD_RDSTB = 4'h3,
    WDT_CMD_CLRST = 4'h4
  } wdt_cmd_e;
  typedef logic [7:0] wdt_byte_t;
endpackage

//--- wdt_remain.sv
// Maps remaining time in half-minute units to the read-back bucket code
`timescale 1ns/1ns
`default_nettype none
module wdt_remain (
  input wire logic [7:0] i_halfmin, // Remaining half-minutes, rounded up
  output logic [3:0] o_code // Bucket code
);
  always_comb begin
    if (i_halfmin == 8'h00) o_code = 4'h0;
    else if (i_halfmin <= 8'h01) o_code = 4'h1;
    else if (i_halfmin <= 8'h02) o_code = 4'h2;
    else if (i_halfmin <= 8'h04) o_code = 4'h3;
    else if (i_halfmin <= 8'h06) o_code = 4'h4;
    else if (i_halfmin <= 8'h08) o_code = 4'h5;
    else if (i_halfmin <= 8'h0A) o_code = 4'h6;
    else if (i_halfmin <= 8'h14) o_code = 4'h7;
    else if (i_halfmin <= 8'h1E) o_code = 4'h8;
    else if (i_halfmin <= 8'h28) o_code = 4'h9;
    else if (i_halfmin <= 8'h3C) o_code = 4'hA;
    else if (i_halfmin <= 8'h50) o_code = 4'hB;
    else if (i_halfmin <= 8'h78) o_code = 4'hC;
    else if (i_halfmin <= 8'h96) o_code = 4'hD;
    else if (i_halfmin <= 8'hB4) o_code = 4'hE;
    else o_code = 4'hF;
  end
endmodule
`default_nettype wire

//--- wdt_sync.sv
// Three-stage pin synchroniser with agreement check
`timescale 1ns/1ns
`default_nettype none
module wdt_sync (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_pin, // Asynchronous pin
  output logic o_level // Filtered level
);
  logic s1, s2, s3;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      // Only stages two and three are compared; stage one is metastable-prone
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

//--- wdt_top.sv
// Watchdog and software discharge timer with AHB-Lite register access
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"
module wdt_top #(
  parameter int unsigned WDOG_CYC = `WDT_WDOG_CYC,
  parameter int unsigned HALFMIN_CYC = `WDT_HALFMIN_CYC,
  parameter logic [3:0] REV_CODE = 4'h1 // Arbitrary revision value
) (
  input wire logic I_CLK, // Clock, 10 MHz
  input wire logic I_RST, // Synchronous reset, active high
  input wire logic I_HSEL, // Slave select
  input wire logic [31:0] I_HADDR, // Byte address
  input wire logic [1:0] I_HTRANS, // Transfer type
  input wire logic I_HWRITE, // Write when high
  input wire logic [2:0] I_HSIZE, // Transfer size
  input wire logic [31:0] I_HWDATA, // Write data
  input wire logic I_HREADY, // Bus ready in
  output logic [31:0] O_HRDATA, // Read data
  output logic O_HREADYOUT, // Slave ready
  output logic O_HRESP, // Always OKAY
  input wire logic I_WAKE, // Qualified wake-up pin, active high
  input wire logic I_SOFT_TIMER_ENABLE_PIN, // Software timer enable pin
  input wire logic I_THERMAL_TRIP, // Thermal shutdown trip pin
  output logic O_WATCHDOG_EXPIRED_PIN_OE, // Pulls pin low while high
  output logic [11:0] O_DISCHARGE // Discharge switch controls
);
  import wdt_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic wake_lvl, soft_timer_enable_pin_lvl, therm_lvl, wake_d, therm_d;
  wdt_sync u_sync_wake (.i_clk(I_CLK), .i_rst(I_RST), .i_pin(I_WAKE), .o_level(wake_lvl));
  wdt_sync u_sync_soft_timer_enable_pin (.i_clk(I_CLK), .i_rst(I_RST), .i_pin(I_SOFT_TIMER_ENABLE_PIN), .o_level(soft_timer_enable_pin_lvl));
  wdt_sync u_sync_therm (.i_clk(I_CLK), .i_rst(I_RST), .i_pin(I_THERMAL_TRIP), .o_level(therm_lvl));

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wake_d <= 1'b0;
      therm_d <= 1'b0;
    end else begin
      wake_d <= wake_lvl;
      therm_d <= therm_lvl;
    end
  end

  logic wake_evt, therm_evt, sw_wake;
  assign wake_evt = (wake_lvl & ~wake_d) | sw_wake;
  assign therm_evt = therm_lvl & ~therm_d;

  // ==========================================================
  // Bus slave
  wdt_req_s req;
  logic req_valid;
  logic [31:0] rd_mux;
  logic [47:0] config_bytes, wdata_buf, rdata_buf;
  logic thermal_shutdown_flag, timer_running, wdog_expired;
  logic [3:0] remain_code;
  logic [3:0] cmd_pulse;
  logic [7:0] statb;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a[7:0] == ofs[7:0]) && (a[31:8] == 24'h00_0000);
  endfunction

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      req <= '0;
      req_valid <= 1'b0;
    end else begin
      req_valid <= I_HSEL & I_HREADY & I_HTRANS[1];
      if (I_HSEL & I_HREADY & I_HTRANS[1]) begin
        req.addr <= I_HADDR;
        req.write <= I_HWRITE;
      end
    end
  end

  assign statb = {REV_CODE, 2'b00, 1'b0, thermal_shutdown_flag};

  // Reads are decoded in the address phase so the data stand through the whole data phase.
  // Limitation: a read whose address phase falls in the data phase of a write to the same word sees the old value.
  logic rd_take;
  assign rd_take = I_HSEL & I_HREADY & I_HTRANS[1] & ~I_HWRITE;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(I_HADDR, `WDT_OFS_CFG_LO)) rd_mux = config_bytes[31:0];
    else if (hit(I_HADDR, `WDT_OFS_CFG_HI)) rd_mux = {16'h0000, remain_code, config_bytes[43:32]};
    else if (hit(I_HADDR, `WDT_OFS_WDATA_LO)) rd_mux = wdata_buf[31:0];
    else if (hit(I_HADDR, `WDT_OFS_WDATA_HI)) rd_mux = {16'h0000, wdata_buf[47:32]};
    else if (hit(I_HADDR, `WDT_OFS_STATB)) rd_mux = {24'h00_0000, statb};
    else if (hit(I_HADDR, `WDT_OFS_STATUS)) rd_mux = {29'h0000_0000, timer_running, wdog_expired, soft_timer_enable_pin_lvl};
    else if (hit(I_HADDR, `WDT_OFS_RDATA_LO)) rd_mux = rdata_buf[31:0];
    else if (hit(I_HADDR, `WDT_OFS_RDATA_HI)) rd_mux = {16'h0000, rdata_buf[47:32]};
  end

  // Zero wait states: read data are registered at the address-phase edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_HRDATA <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      if (rd_take) begin
        O_HRDATA <= rd_mux;
      end
    end
  end

  // Data phase write decode
  logic wr_now;
  assign wr_now = req_valid & req.write;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wdata_buf <= `WDT_CFG_RESET;
      cmd_pulse <= WDT_CMD_NONE;
      sw_wake <= 1'b0;
    end else begin
      cmd_pulse <= WDT_CMD_NONE;
      sw_wake <= 1'b0;
      if (wr_now && hit(req.addr, `WDT_OFS_WDATA_LO)) wdata_buf[31:0] <= I_HWDATA;
      if (wr_now && hit(req.addr, `WDT_OFS_WDATA_HI)) wdata_buf[47:32] <= I_HWDATA[15:0];
      if (wr_now && hit(req.addr, `WDT_OFS_CMD)) cmd_pulse <= I_HWDATA[3:0];
      if (wr_now && hit(req.addr, `WDT_OFS_WAKE)) sw_wake <= I_HWDATA[0];
    end
  end

  // ==========================================================
  // Watchdog
  logic [31:0] wdog_cnt;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wdog_cnt <= 32'h0000_0000;
      wdog_expired <= 1'b0;
    end else if (wake_evt) begin
      wdog_cnt <= 32'h0000_0000;
      wdog_expired <= 1'b0;
    end else if (wdog_cnt < WDOG_CYC) begin
      wdog_cnt <= wdog_cnt + 32'h0000_0001;
    end else begin
      wdog_expired <= 1'b1;
    end
  end
  logic wdog_fire;
  assign wdog_fire = ~wake_evt & (wdog_cnt == WDOG_CYC - 1);

  // ==========================================================
  // Software discharge timer
  logic [3:0] discharge_timeout_code;
  logic timer_en;
  logic [7:0] halfmin_left;
  logic [31:0] sub_cnt;
  logic timer_fire, cfg_write;
  assign discharge_timeout_code = config_bytes[47:44];
  assign timer_en = soft_timer_enable_pin_lvl & (discharge_timeout_code != 4'h0);
  assign cfg_write = (cmd_pulse == WDT_CMD_WRITE_CONFIG_CMD);
  assign timer_fire = timer_running & (halfmin_left == 8'h01) & (sub_cnt == HALFMIN_CYC - 1);

  function automatic logic [7:0] dur_halfmin(input logic [3:0] c);
    case (c)
      4'h1: dur_halfmin = 8'd1;
      4'h2: dur_halfmin = 8'd2;
      4'h3: dur_halfmin = 8'd4;
      4'h4: dur_halfmin = 8'd6;
      4'h5: dur_halfmin = 8'd8;
      4'h6: dur_halfmin = 8'd10;
      4'h7: dur_halfmin = 8'd20;
      4'h8: dur_halfmin = 8'd30;
      4'h9: dur_halfmin = 8'd40;
      4'hA: dur_halfmin = 8'd60;
      4'hB: dur_halfmin = 8'd80;
      4'hC: dur_halfmin = 8'd120;
      4'hD: dur_halfmin = 8'd150;
      4'hE: dur_halfmin = 8'd180;
      4'hF: dur_halfmin = 8'd240;
      default: dur_halfmin = 8'd0;
    endcase
  endfunction

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      halfmin_left <= 8'h00;
      sub_cnt <= 32'h0000_0000;
      timer_running <= 1'b0;
    end else if (cfg_write) begin
      halfmin_left <= dur_halfmin(wdata_buf[47:44]);
      sub_cnt <= 32'h0000_0000;
      timer_running <= soft_timer_enable_pin_lvl & (wdata_buf[47:44] != 4'h0);
    end else if (~timer_en | therm_evt) begin
      halfmin_left <= 8'h00;
      timer_running <= 1'b0;
    end else if (timer_running) begin
      if (sub_cnt == HALFMIN_CYC - 1) begin
        sub_cnt <= 32'h0000_0000;
        halfmin_left <= halfmin_left - 8'h01;
        if (halfmin_left == 8'h01) timer_running <= 1'b0;
      end else begin
        sub_cnt <= sub_cnt + 32'h0000_0001;
      end
    end
  end

  wdt_remain u_remain (.i_halfmin(timer_running ? halfmin_left : 8'h00), .o_code(remain_code));

  // ==========================================================
  // Configuration group
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      config_bytes <= `WDT_CFG_RESET;
    end else if (cfg_write) begin
      config_bytes <= wdata_buf;
    end else if (therm_evt) begin
      config_bytes <= `WDT_CFG_RESET;
    end else begin
      if (wdog_fire) config_bytes[31:0] <= 32'(`WDT_CFG_RESET);
      if ((wdog_fire & ~timer_running) | timer_fire) begin
        config_bytes[47:32] <= 16'(`WDT_CFG_RESET >> 32);
      end
      // Active timer leaves bytes four and five holding the switches
    end
  end

  // Read-config snapshot; a timer firing here may leave bytes four, five stale
  always_ff @(posedge I_CLK) begin
    if (I_RST) rdata_buf <= `WDT_CFG_RESET;
    else if (cmd_pulse == WDT_CMD_READ_CONFIG_CMD) rdata_buf <= {remain_code, config_bytes[43:0]};
    else if (cmd_pulse == WDT_CMD_RDSTB) rdata_buf <= {40'h00_0000_0000, statb};
  end

  // ==========================================================
  // Thermal flag: set wins over clear
  logic statb_read;
  // Cleared on the same edge that captures the read value, so a trip in between is never lost
  assign statb_read = (rd_take && hit(I_HADDR, `WDT_OFS_STATB)) | (cmd_pulse == WDT_CMD_RDSTB);
  always_ff @(posedge I_CLK) begin
    if (I_RST) thermal_shutdown_flag <= 1'b0;
    else if (therm_evt | (cmd_pulse == WDT_CMD_CLRST)) thermal_shutdown_flag <= 1'b1;
    else if (statb_read) thermal_shutdown_flag <= 1'b0;
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_WATCHDOG_EXPIRED_PIN_OE <= 1'b1;
      O_DISCHARGE <= 12'h000;
    end else begin
      O_WATCHDOG_EXPIRED_PIN_OE <= ~(wdog_expired | wdog_fire);
      O_DISCHARGE <= {config_bytes[43:40], config_bytes[39:32]};
    end
  end
endmodule
`default_nettype wire
